// >>> eepc_consts.vh
`ifndef EEPC_CONSTS_VH
`define EEPC_CONSTS_VH
// register byte offsets
`define EEPC_OFS_PROG     12'h000
`define EEPC_OFS_PROTECT  12'h004
`define EEPC_OFS_OPTION   12'h008
`define EEPC_OFS_STATUS   12'h00c
`define EEPC_OFS_MODE     12'h010
// array window and setup register address
`define EEPC_ARR_BASE     12'h800
`define EEPC_ARR_LAST     12'h9ff
`define EEPC_SETUP_ADDR   12'h03f
// program control field positions
`define EEPC_B_VOLT       0
`define EEPC_B_LATCH      1
`define EEPC_B_ERASE      2
`define EEPC_B_ROW        3
`define EEPC_B_BYTE       4
// protect register fields
`define EEPC_B_SETUP_PROT 4
// option register fields
`define EEPC_B_PUMP_CLK   0
`define EEPC_B_SECURE     1
// reset values
`define EEPC_RST_PROG     8'h00
`define EEPC_RST_PROTECT  8'h1f
`define EEPC_RST_OPTION   8'h00
// operation codes
`define EEPC_OP_PROG      3'h1
`define EEPC_OP_BYTE_ER   3'h2
`define EEPC_OP_ROW_ER    3'h3
`define EEPC_OP_BULK_ER   3'h4
`define EEPC_OP_NONE      3'h0
// timing: typical pulse 10 ms at 40 MHz
`define EEPC_PULSE_MS     10
`define EEPC_CLK_KHZ      40000
`endif

// >>> eepc_ctrl.v
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "eepc_consts.vh"
module eepc_ctrl #(
  parameter integer PULSE_CYC = (`EEPC_PULSE_MS * `EEPC_CLK_KHZ)
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  output reg         hv_on,
  output reg         arr_prog_mode,
  output reg         pump_clk_rc,
  output reg         single_chip_only,
  output reg  [2:0]  cell_op,
  output reg  [11:0] cell_addr,
  output reg  [7:0]  cell_data
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  reg  [7:0]  prog_ctl_ff;    // program control register
  reg  [7:0]  protect_ff;     // block protect register
  reg  [7:0]  option_ff;      // pump clock and security
  reg         tgt_valid_ff;   // a target was captured
  reg         tgt_setup_ff;   // target is the setup register
  reg  [11:0] tgt_addr_ff;    // captured address
  reg  [7:0]  tgt_data_ff;    // captured data
  reg  [31:0] pulse_cnt_ff;   // cycles of voltage bit set so far
  reg         wr_pend_ff;     // data phase of a write pending
  reg  [11:0] wr_addr_ff;     // address of that write
  reg         mode_pin_s1_ff; // synchroniser first stage
  reg         mode_pin_s2_ff; // synchroniser second stage
  wire [7:0]  wd;             // written byte
  wire        addr_ph;        // valid address phase
  reg  [31:0] rd_mux;         // read data selection
  reg  [2:0]  nxt_op;         // decoded operation

  assign wd      = hwdata[7:0];
  assign addr_ph = hsel & hready & htrans[1];

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // is the address inside the array window
  function in_array;
    input [11:0] a;
    begin
      in_array = (a >= `EEPC_ARR_BASE) && (a <= `EEPC_ARR_LAST);
    end
  endfunction

  // operation from control bits
  function [2:0] op_of;
    input [7:0] c;
    begin
      if (!c[`EEPC_B_ERASE])
        op_of = `EEPC_OP_PROG;
      else if (c[`EEPC_B_BYTE])
        op_of = `EEPC_OP_BYTE_ER;
      else if (c[`EEPC_B_ROW])
        op_of = `EEPC_OP_ROW_ER;
      else
        op_of = `EEPC_OP_BULK_ER;
    end
  endfunction

  // ----------------------------------------
  // bus slave: address capture, zero wait
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
    end else begin
      wr_pend_ff <= addr_ph & hwrite;
      if (addr_ph)
        wr_addr_ff <= haddr[11:0];
    end
  end

  // security bit from the option register, synchronised
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_pin_s1_ff <= 1'b0;
      mode_pin_s2_ff <= 1'b0;
    end else begin
      mode_pin_s1_ff <= option_ff[`EEPC_B_SECURE];
      mode_pin_s2_ff <= mode_pin_s1_ff;
    end
  end

  // ----------------------------------------
  // control registers and target capture
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_ctl_ff  <= `EEPC_RST_PROG;
      protect_ff   <= `EEPC_RST_PROTECT;
      option_ff    <= `EEPC_RST_OPTION;
      tgt_valid_ff <= 1'b0;
      tgt_setup_ff <= 1'b0;
      tgt_addr_ff  <= 12'h000;
      tgt_data_ff  <= 8'h00;
    end else if (wr_pend_ff) begin
      case (wr_addr_ff)
        `EEPC_OFS_PROG: begin
          if (wd[`EEPC_B_LATCH] & wd[`EEPC_B_VOLT] & ~prog_ctl_ff[`EEPC_B_LATCH])
            prog_ctl_ff <= {3'h0, wd[4:2], 2'b00};
          // voltage only with latch already on and a target
          else if (wd[`EEPC_B_VOLT] & ~(prog_ctl_ff[`EEPC_B_LATCH] & tgt_valid_ff))
            prog_ctl_ff <= {3'h0, wd[4:1], 1'b0};
          else
            prog_ctl_ff <= {3'h0, wd[4:0]};
          if (!wd[`EEPC_B_LATCH])
            tgt_valid_ff <= 1'b0;
        end
        // protect bits may be set any time, cleared freely here
        `EEPC_OFS_PROTECT: protect_ff <= {3'h0, wd[4:0]};
        `EEPC_OFS_OPTION:  option_ff  <= {6'h00, wd[1:0]};
        default: begin
          if (prog_ctl_ff[`EEPC_B_LATCH] & ~prog_ctl_ff[`EEPC_B_VOLT] &
              (in_array(wr_addr_ff) | (wr_addr_ff == `EEPC_SETUP_ADDR))) begin
            tgt_valid_ff <= 1'b1;
            // setup address as a byte target
            tgt_setup_ff <= (wr_addr_ff == `EEPC_SETUP_ADDR);
            tgt_addr_ff  <= wr_addr_ff;
            tgt_data_ff  <= wd;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // pulse timer, status only
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      pulse_cnt_ff <= 32'h0;
    else if (!prog_ctl_ff[`EEPC_B_VOLT])
      pulse_cnt_ff <= 32'h0;
    else if (pulse_cnt_ff != PULSE_CYC)
      pulse_cnt_ff <= pulse_cnt_ff + 32'h1;
  end

  // ----------------------------------------
  // cell-side outputs
  // ----------------------------------------
  always @* begin
    nxt_op = op_of(prog_ctl_ff);
    if (tgt_setup_ff & protect_ff[`EEPC_B_SETUP_PROT])
      nxt_op = `EEPC_OP_NONE;
    if (tgt_setup_ff & (nxt_op == `EEPC_OP_BULK_ER))
      nxt_op = `EEPC_OP_NONE;
    // four 128-byte blocks across the array, one protect bit each
    if (~tgt_setup_ff & protect_ff[tgt_addr_ff[8:7]])
      nxt_op = `EEPC_OP_NONE;
    if (~tgt_valid_ff)
      nxt_op = `EEPC_OP_NONE;
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hv_on            <= 1'b0;
      arr_prog_mode    <= 1'b0;
      pump_clk_rc      <= 1'b0;
      single_chip_only <= 1'b0;
      cell_op          <= `EEPC_OP_NONE;
      cell_addr        <= 12'h000;
      cell_data        <= 8'h00;
    end else begin
      hv_on            <= prog_ctl_ff[`EEPC_B_VOLT] & (nxt_op != `EEPC_OP_NONE);
      // latch puts array in program mode
      arr_prog_mode    <= prog_ctl_ff[`EEPC_B_LATCH];
      pump_clk_rc      <= option_ff[`EEPC_B_PUMP_CLK];
      single_chip_only <= mode_pin_s2_ff;
      cell_op          <= prog_ctl_ff[`EEPC_B_VOLT] ? nxt_op : `EEPC_OP_NONE;
      cell_addr        <= tgt_addr_ff;
      cell_data        <= tgt_data_ff;
    end
  end

  // ----------------------------------------
  // read data, always OKAY, no waits
  // ----------------------------------------
  always @* begin
    case (haddr[11:0])
      `EEPC_OFS_PROG:    rd_mux = {24'h0, prog_ctl_ff};
      `EEPC_OFS_PROTECT: rd_mux = {24'h0, protect_ff};
      `EEPC_OFS_OPTION:  rd_mux = {24'h0, option_ff};
      `EEPC_OFS_STATUS:  rd_mux = {29'h0, (pulse_cnt_ff == PULSE_CYC), tgt_valid_ff, hv_on};
      default:           rd_mux = 32'h0;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_ph & ~hwrite)
        hrdata <= rd_mux;
    end
  end
endmodule // eepc_ctrl

// >>> eepc_ctrl_monitor.sv
`timescale 1ns/1ps
`include "eepc_consts.vh"
module eepc_ctrl_monitor (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire        hv_on,
  input wire        arr_prog_mode,
  input wire        pump_clk_rc,
  input wire        single_chip_only,
  input wire [2:0]  cell_op
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------
  // data phase decode
  // ----------
  reg        wv_ff; // write in data phase
  reg [11:0] wa_ff; // its address
  reg [2:0]  op_ff; // op implied by last control write
  wire ctl_wr = wv_ff && hready && wa_ff == `EEPC_OFS_PROG;
  wire opt_wr = wv_ff && hready && wa_ff == `EEPC_OFS_OPTION;
  // scope decode kept apart from the design so a swapped priority shows up
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wv_ff <= 1'b0;
      wa_ff <= 12'h000;
      op_ff <= 3'h0;
    end else begin
      if (hready) begin
        wv_ff <= hsel & htrans[1] & hwrite;
        wa_ff <= haddr[11:0];
      end
      if (ctl_wr) op_ff <= !hwdata[2] ? 3'h1 : hwdata[4] ? 3'h2 : hwdata[3] ? 3'h3 : 3'h4;
    end
  end
  sequence s_ctl_clear;
    ctl_wr && hwdata[7:0] == 8'h00;
  endsequence
  sequence s_ctl_both;
    ctl_wr && hwdata[1:0] == 2'h3 && !arr_prog_mode;
  endsequence
  sequence s_off;
    !hv_on && !arr_prog_mode;
  endsequence
  AST_RSP:
    assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
  AST_HV_LATCH:
    assert property (hv_on |-> arr_prog_mode && cell_op != 3'h0) else $error("voltage without latch or op");
  AST_OP:
    assert property ($rose(hv_on) |-> cell_op == op_ff) else $error("wrong operation scope");
  AST_STABLE:
    assert property (hv_on && $past(hv_on) |-> $stable(cell_op)) else $error("op changed during pulse");
  AST_CLEAR:
    assert property (s_ctl_clear |-> ##[1:3] s_off) else $error("clear left voltage or latch on");
  AST_BOTH:
    assert property (s_ctl_both |=> s_off [*2]) else $error("latch and voltage set together");
  AST_SECURE:
    assert property (opt_wr && hwdata[1] |-> ##[1:4] single_chip_only) else $error("security not applied");
  AST_PUMP:
    assert property (opt_wr && hwdata[0] |-> ##[1:3] pump_clk_rc) else $error("pump clock not switched");
endmodule // eepc_ctrl_monitor
bind eepc_ctrl eepc_ctrl_monitor eepc_ctrl_monitor_inst (.*);

// >>> eepc_ctrl_bench.sv
`timescale 1ns/1ps
`include "eepc_consts.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module eepc_ctrl_bench;
  reg         hclk = 1'b0;
  reg         hresetn = 1'b0;
  reg         hsel = 1'b0;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  reg  [31:0] rd;
  wire [31:0] hrdata;
  wire        hreadyout, hresp, hv_on, arr_prog_mode, pump_clk_rc, single_chip_only;
  wire [2:0]  cell_op;
  wire [11:0] cell_addr;
  wire [7:0]  cell_data;
  integer     mismatches = 0;
  integer     cmp_count = 0;
  always #12.5 hclk = ~hclk;
  // short pulse keeps the run brief
  eepc_ctrl #(.PULSE_CYC(20)) eepc_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .hv_on(hv_on), .arr_prog_mode(arr_prog_mode), .pump_clk_rc(pump_clk_rc),
    .single_chip_only(single_chip_only), .cell_op(cell_op), .cell_addr(cell_addr), .cell_data(cell_data));
  // one single word transfer, read data kept in rd
  task xfer(input [11:0] a, input w, input [31:0] d);
    begin
      hsel <= 1'b1;
      haddr <= {20'h00000, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
    end
  endtask
  task chk_reg(input [11:0] a, input [31:0] e);
    begin
      xfer(a, 1'b0, 32'h0);
      `CHK(rd, e)
    end
  endtask
  task wait_cyc(input integer n);
    begin
      repeat (n) @(posedge hclk);
      #1;
    end
  endtask
  // latch, target write, voltage, wait, clear
  task pulse(input [7:0] c, input [11:0] a, input [2:0] op);
    begin
      xfer(`EEPC_OFS_PROG, 1'b1, {24'h0, c});
      wait_cyc(2);
      `CHK(arr_prog_mode, 1'b1)
      xfer(a, 1'b1, 32'h5a);
      xfer(`EEPC_OFS_PROG, 1'b1, {24'h0, c | 8'h01});
      wait_cyc(3);
      `CHK({hv_on, cell_op}, {op != 3'h0, op})
      if (op != 3'h0) `CHK({cell_addr, cell_data}, {a, 8'h5a})
      wait_cyc(20);
      chk_reg(`EEPC_OFS_STATUS, {29'h0, 2'h3, op != 3'h0});
      xfer(`EEPC_OFS_PROG, 1'b1, 32'h0);
      wait_cyc(3);
      `CHK({hv_on, arr_prog_mode, cell_op}, 5'h00)
    end
  endtask
  task report_and_stop;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #200000;
    mismatches++;
    report_and_stop;
  end
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_reg(`EEPC_OFS_PROG, 32'h0);
    chk_reg(`EEPC_OFS_PROTECT, 32'h1f);
    chk_reg(`EEPC_OFS_OPTION, 32'h0);
    chk_reg(12'h0fc, 32'h0);
    xfer(`EEPC_OFS_PROG, 1'b1, 32'h3);
    chk_reg(`EEPC_OFS_PROG, 32'h0);
    $display("reset and refusal test done");
    xfer(`EEPC_OFS_PROTECT, 1'b1, 32'h10);
    pulse(8'h1a, 12'h800, `EEPC_OP_PROG);
    pulse(8'h06, 12'h810, `EEPC_OP_BULK_ER);
    pulse(8'h0e, 12'h810, `EEPC_OP_ROW_ER);
    pulse(8'h16, 12'h810, `EEPC_OP_BYTE_ER);
    pulse(8'h1e, 12'h9ff, `EEPC_OP_BYTE_ER);
    $display("array test done");
    pulse(8'h16, `EEPC_SETUP_ADDR, `EEPC_OP_NONE);
    xfer(`EEPC_OFS_PROTECT, 1'b1, 32'h0);
    pulse(8'h06, `EEPC_SETUP_ADDR, `EEPC_OP_NONE);
    pulse(8'h16, `EEPC_SETUP_ADDR, `EEPC_OP_BYTE_ER);
    pulse(8'h02, `EEPC_SETUP_ADDR, `EEPC_OP_PROG);
    $display("setup register test done");
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_reg(`EEPC_OFS_PROTECT, 32'h1f);
    `CHK({hv_on, arr_prog_mode, cell_op}, 5'h00)
    xfer(`EEPC_OFS_PROTECT, 1'b1, 32'h0);
    $display("mid-run reset test done");
    xfer(`EEPC_OFS_OPTION, 1'b1, 32'h3);
    wait_cyc(4);
    `CHK({pump_clk_rc, single_chip_only}, 2'h3)
    chk_reg(`EEPC_OFS_OPTION, 32'h3);
    pulse(8'h02, 12'h9ff, `EEPC_OP_PROG);
    $display("option test done");
    report_and_stop;
  end
endmodule // eepc_ctrl_bench
